// ===== ptte_pkg.sv
package ptte_pkg;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam logic [7:0] NOM_STEP = 8'(CLK_PERIOD_NS);
	localparam logic [29:0] NS_PER_SEC = 30'h3B9ACA00;
	localparam logic [47:0] NS_PER_SEC48 = 48'h00003B9ACA00;
	localparam int FIFO_DEPTH = 1024;
	localparam int FIFO_AW = 10;
	localparam logic [10:0] FIFO_ROOM2 = 11'h3FE;
	// ---------------------------------------------------------------
	// Port modes, commands, preamble, actions
	// ---------------------------------------------------------------
	localparam logic [2:0] MODE_FRONT = 3'h0;
	localparam logic [2:0] MODE_RESERVED_TOD_NS = 3'h1;
	localparam logic [2:0] MODE_RESERVED_NS32 = 3'h2;
	localparam logic [2:0] MODE_ADD_SUB44 = 3'h3;
	localparam logic [2:0] MODE_ADD_SUB48 = 3'h4;
	localparam logic [2:0] MODE_MONITOR = 3'h5;
	localparam logic [2:0] MODE_DISABLED = 3'h6;
	localparam logic [1:0] CMD_NOP = 2'h0;
	localparam logic [1:0] CMD_ONE = 2'h1;
	localparam logic [1:0] CMD_TWO = 2'h2;
	localparam logic [1:0] CMD_TOD = 2'h3;
	localparam logic [1:0] DLY_EGRESS = 2'h1;
	localparam logic [1:0] DLY_INGRESS1 = 2'h2;
	localparam logic [1:0] DLY_INGRESS2 = 2'h3;
	localparam logic [1:0] PRE_NONE = 2'h0;
	localparam logic [1:0] PRE_CORR = 2'h1;
	localparam logic [1:0] PRE_CORR_RSV = 2'h2;
	localparam logic [1:0] ACT_LOAD = 2'h0;
	localparam logic [1:0] ACT_DELTA = 2'h1;
	localparam logic [1:0] ACT_STORE = 2'h2;
	localparam logic [1:0] ACT_CLOCK = 2'h3;
	localparam logic [1:0] RATE_ADD = 2'h1;
	localparam logic [1:0] RATE_DROP = 2'h2;
	localparam logic [47:0] CF_MAX = 48'h7FFFFFFFFFFF;
	localparam logic [49:0] CF_WRAP44 = 50'h00100000000000;
	// ---------------------------------------------------------------
	// Register map and fields
	// ---------------------------------------------------------------
	localparam logic [11:0] A_RATE_CFG = 12'h000;
	localparam logic [11:0] A_RATE_INT = 12'h004;
	localparam logic [11:0] A_FIFO_INFO = 12'h008;
	localparam logic [11:0] A_FIFO_DATA = 12'h00C;
	localparam logic [11:0] A_STICKY = 12'h010;
	localparam logic [11:0] A_IRQ_STAT = 12'h014;
	localparam logic [11:0] A_IRQ_MASK = 12'h018;
	localparam logic [11:0] A_PORT_BASE = 12'h020;
	localparam logic [11:0] A_PORT_END = 12'h080;
	localparam logic [11:0] A_CTRL_END = 12'h120;
	localparam int CTL_SYNC_BIT = 2;
	localparam int CTL_INV_BIT = 3;
	localparam int CTL_ARM_BIT = 4;
	localparam int STICKY_OVF_LSB = 8;
	localparam int FIFO_NE_BIT = 31;
	localparam int FIFO_DIR_BIT = 3;
	localparam logic [31:0] RST_WORD = 32'h00000000;
endpackage

// ===== ptte_engine.sv
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - One-step adds the selected ingress or egress delay to the correction field.
// - Disabled or monitor ingress modes are computed as front on ingress.
// - Preamble asks for correction-only or correction plus reserved, with free count.
// - Front ingress adds free count minus stamp; front egress asks correction preamble.
// - Tod-ns mode: ingress adds tod ns minus reserved; egress writes ns, reserved preamble.
// - Ns32 mode: ingress adds low 32 ns minus reserved; egress writes low 32 ns.
// - Add-sub44: egress subtracts, marks bit 46; ingress adds, fixes wrap, copies 47.
// - Monitor egress subtracts residence time; disabled egress leaves timing fields unchanged.
// - Per-port sticky flag for received frames with nonzero reserved bytes.
// - Out-of-range correction saturates to max and sets sticky; skipped in add-sub48.
// - Software-read stamp FIFO of 1024 entries with stamp, port, direction.
// - Two-step pushes egress entry first, then ingress entry.
// - Two-step forwards frames without adding any delay.
// - Time-of-day action writes origin time and asks correction preamble.
// - Time advances each cycle by nominal period plus zero, one or minus one.
// - Rate adjust inserts or drops one ns at a programmed interval.
// - Five controllers; the first four use pins zero to three, fifth none.
// - Controllers hold a time set, load or capture it, now or on edge.
// - Actions are load, add delta, store, or clock output.
// - Storage is 48 s, 30 ns, 32 free count; free count never loaded.
// - Sync waits for an edge or gives one pulse; inverse uses falling edges.
// - Clock uses high and low ns; pulse uses width and delay after ns zero.
// - Each executed operation raises a maskable interrupt; clock at active level.
module ptte_engine
	import ptte_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Frame descriptor from the analyzer
	input wire logic fr_valid,
	input wire logic [1:0] fr_cmd,
	input wire logic [1:0] fr_dly,
	input wire logic [2:0] fr_ing,
	input wire logic [2:0] fr_egr,
	input wire logic [47:0] fr_cf,
	input wire logic [31:0] fr_stamp,
	input wire logic [31:0] fr_rsv,
	input wire logic [31:0] fr_egr_stamp,
	// Rewritten frame fields and preamble
	output logic rw_valid,
	output logic [47:0] rw_cf,
	output logic [31:0] rw_rsv,
	output logic rw_rsv_wr,
	output logic [47:0] rw_org_sec,
	output logic [29:0] rw_org_ns,
	output logic rw_org_wr,
	output logic [1:0] rw_pre_cmd,
	output logic [31:0] rw_pre_ref,
	// Time of day
	output logic [47:0] tod_seconds,
	output logic [29:0] tod_nanoseconds,
	output logic [31:0] free_ns_counter,
	// Timing pins and interrupt
	input wire logic [3:0] pin_in,
	output logic [3:0] pin_out,
	output logic [3:0] pin_oe_n,
	output logic irq
);
	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------
	function automatic logic [49:0] sx32(input logic [31:0] v);
		return {{18{v[31]}}, v};
	endfunction
	function automatic logic [30:0] ns_add(input logic [29:0] a, input logic [29:0] b);
		logic [30:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= {1'b0, NS_PER_SEC})
			return {1'b1, 30'(s - {1'b0, NS_PER_SEC})};
		return {1'b0, s[29:0]};
	endfunction
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [47:0] sec_q;
	logic [29:0] ns_q;
	logic [31:0] free_q;
	logic [1:0] rmode_q;
	logic [31:0] rint_q, rcnt_q;
	logic [2:0] mode_q [0:7];
	logic [31:0] idly1_q [0:7], idly2_q [0:7], egress_delay_q [0:7];
	logic [5:0] rsv_st_q, ovf_st_q;
	logic [4:0] ist_q, imask_q, arm_q, lvl_q;
	logic [4:0] ctl_q [0:4];
	logic [47:0] ts_sec_q [0:4];
	logic [29:0] ts_ns_q [0:4];
	logic [31:0] ts_free_q [0:4], whi_q [0:4], wlo_q [0:4], ph_q [0:4];
	logic [3:0] pin_prev_q;
	logic [35:0] fifo_mem [0:FIFO_DEPTH-1];
	logic [FIFO_AW-1:0] wp_q, rp_q;
	logic [10:0] cnt_q;
	logic pend_q;
	logic [35:0] pend_ent_q;
	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire in_port = paddr >= A_PORT_BASE && paddr < A_PORT_END;
	wire in_ctl = paddr >= A_PORT_END && paddr < A_CTRL_END;
	wire [11:0] coff = paddr - A_PORT_END;
	wire [2:0] pidx = paddr[6:4] - 3'h2;
	wire [2:0] cidx = coff[7:5];
	wire [2:0] cfld = coff[4:2];
	wire ctl_ok = in_ctl && cfld < 3'h7 && paddr[1:0] == 2'h0;
	wire fix_ok = paddr <= A_IRQ_MASK && paddr[1:0] == 2'h0;
	wire map_ok = fix_ok || (in_port && paddr[1:0] == 2'h0) || ctl_ok;
	wire fifo_ne = cnt_q != 11'h000;
	wire pop = acc & ~pwrite & paddr == A_FIFO_DATA & fifo_ne;
	// An empty FIFO reads as zero, never as a stale or unwritten entry.
	wire [35:0] fifo_head = fifo_ne ? fifo_mem[rp_q] : 36'h0;
	logic [31:0] rd;
	always_comb
	begin
		rd = RST_WORD;
		case (paddr)
			A_RATE_CFG: rd = {30'h0, rmode_q};
			A_RATE_INT: rd = rint_q;
			A_FIFO_INFO: rd = {fifo_ne, 27'h0, fifo_head[35:32]};
			A_FIFO_DATA: rd = fifo_head[31:0];
			A_STICKY: rd = {18'h0, ovf_st_q, 2'h0, rsv_st_q};
			A_IRQ_STAT: rd = {27'h0, ist_q};
			A_IRQ_MASK: rd = {27'h0, imask_q};
			default:
			begin
				if (in_port)
					case (paddr[3:2])
						2'h0: rd = {29'h0, mode_q[pidx]};
						2'h1: rd = idly1_q[pidx];
						2'h2: rd = idly2_q[pidx];
						default: rd = egress_delay_q[pidx];
					endcase
				else if (ctl_ok)
					case (cfld)
						3'h0: rd = {27'h0, arm_q[cidx], ctl_q[cidx][3:0]};
						3'h1: rd = {16'h0, ts_sec_q[cidx][47:32]};
						3'h2: rd = ts_sec_q[cidx][31:0];
						3'h3: rd = {2'h0, ts_ns_q[cidx]};
						3'h4: rd = ts_free_q[cidx];
						3'h5: rd = whi_q[cidx];
						default: rd = wlo_q[cidx];
					endcase
			end
		endcase
	end
	assign prdata = map_ok ? rd : RST_WORD;
	assign pready = 1'b1;
	assign pslverr = acc & ~map_ok;
	// ---------------------------------------------------------------
	// Time of day and rate adjust
	// ---------------------------------------------------------------
	wire rtick = rmode_q != 2'h0 && rcnt_q >= rint_q;
	wire [7:0] step = !rtick ? NOM_STEP : rmode_q == RATE_ADD ? NOM_STEP + 8'h01
		: rmode_q == RATE_DROP ? NOM_STEP - 8'h01 : NOM_STEP;
	wire [47:0] ns_total48 = 48'(sec_q * NS_PER_SEC48) + {18'h0, ns_q};
	logic [4:0] pin_edge, exec;
	always_comb
	begin
		for (int n = 0; n < 5; n++)
		begin
			pin_edge[n] = 1'b0;
			if (n < 4)
				pin_edge[n] = ctl_q[n][CTL_INV_BIT] ? pin_prev_q[n] & ~pin_in[n]
					: ~pin_prev_q[n] & pin_in[n];
			exec[n] = arm_q[n] && ctl_q[n][1:0] != ACT_CLOCK && (!ctl_q[n][CTL_SYNC_BIT] || pin_edge[n]);
		end
	end
	logic ld_hit, dl_hit;
	logic [2:0] ld_idx;
	always_comb
	begin
		ld_hit = 1'b0;
		dl_hit = 1'b0;
		ld_idx = 3'h0;
		for (int n = 4; n >= 0; n--)
			if (exec[n] && ctl_q[n][1:0] != ACT_STORE)
			begin
				ld_hit = 1'b1;
				dl_hit = ctl_q[n][1:0] == ACT_DELTA;
				ld_idx = 3'(n);
			end
	end
	wire [30:0] ns_stepped = ns_add(ns_q, {22'h0, step});
	wire [30:0] ns_delta = ns_add(ns_stepped[29:0], ts_ns_q[ld_idx]);
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sec_q <= 48'h0;
			ns_q <= 30'h0;
			free_q <= RST_WORD;
			rcnt_q <= RST_WORD;
		end
		else
		begin
			free_q <= free_q + {24'h0, step};
			rcnt_q <= rtick ? RST_WORD : rcnt_q + 32'h1;
			if (ld_hit && !dl_hit)
			begin
				sec_q <= ts_sec_q[ld_idx];
				ns_q <= ts_ns_q[ld_idx];
			end
			else if (dl_hit)
			begin
				sec_q <= sec_q + {47'h0, ns_stepped[30]} + {47'h0, ns_delta[30]};
				ns_q <= ns_delta[29:0];
			end
			else
			begin
				sec_q <= sec_q + {47'h0, ns_stepped[30]};
				ns_q <= ns_stepped[29:0];
			end
		end
	end
	assign tod_seconds = sec_q;
	assign tod_nanoseconds = ns_q;
	assign free_ns_counter = free_q;
	// ---------------------------------------------------------------
	// Rewriter arithmetic
	// ---------------------------------------------------------------
	wire [2:0] emode = mode_q[fr_egr];
	wire [2:0] imode_raw = mode_q[fr_ing];
	wire [2:0] imode = (imode_raw == MODE_DISABLED || imode_raw == MODE_MONITOR) ? MODE_FRONT : imode_raw;
	wire [31:0] dly = fr_dly == DLY_EGRESS ? egress_delay_q[fr_egr] : fr_dly == DLY_INGRESS1 ? idly1_q[fr_ing]
		: fr_dly == DLY_INGRESS2 ? idly2_q[fr_ing] : RST_WORD;
	wire [49:0] resid = sx32(free_q - fr_stamp);
	logic [49:0] cf_a, cf_b;
	logic [1:0] pre;
	logic rsv_wr;
	logic [31:0] rsv_v;
	always_comb
	begin
		cf_a = {{2{fr_cf[47]}}, fr_cf} + sx32(dly);
		case (imode)
			MODE_RESERVED_TOD_NS: cf_a = cf_a + sx32({2'h0, ns_q} - fr_rsv);
			MODE_RESERVED_NS32: cf_a = cf_a + sx32(ns_total48[31:0] - fr_rsv);
			MODE_ADD_SUB44:
			begin
				cf_a = cf_a + {6'h0, ns_total48[43:0]} + (fr_cf[46] != ns_total48[44] ? CF_WRAP44 : 50'h0);
				cf_a[46] = cf_a[47];
			end
			MODE_ADD_SUB48: cf_a = cf_a + {2'h0, ns_total48};
			default: cf_a = cf_a + resid;
		endcase
		cf_b = cf_a;
		pre = PRE_NONE;
		rsv_wr = 1'b0;
		rsv_v = fr_rsv;
		case (emode)
			MODE_FRONT: pre = PRE_CORR;
			MODE_RESERVED_TOD_NS:
			begin
				rsv_v = {2'h0, ns_q};
				rsv_wr = 1'b1;
				pre = PRE_CORR_RSV;
			end
			MODE_RESERVED_NS32:
			begin
				rsv_v = ns_total48[31:0];
				rsv_wr = 1'b1;
			end
			MODE_ADD_SUB44:
			begin
				cf_b = cf_a - {6'h0, ns_total48[43:0]};
				cf_b[46] = ns_total48[44];
			end
			MODE_ADD_SUB48: cf_b = cf_a - {2'h0, ns_total48};
			MODE_MONITOR: cf_b = cf_a - resid;
			default: cf_b = {{2{fr_cf[47]}}, fr_cf};
		endcase
	end
	wire one = fr_cmd == CMD_ONE;
	wire chk = imode != MODE_ADD_SUB48 && emode != MODE_ADD_SUB48;
	wire ovf = one && chk && cf_b[49:47] != 3'h0 && cf_b[49:47] != 3'h7;
	wire two_push = fr_valid && fr_cmd == CMD_TWO && cnt_q <= FIFO_ROOM2;
	wire push = two_push || pend_q;
	wire [35:0] push_ent = pend_q ? pend_ent_q : {1'b1, fr_egr, fr_egr_stamp};
	wire [5:0] rsv_set = (fr_valid && fr_cmd != CMD_NOP && fr_rsv != RST_WORD) ? 6'(1 << fr_ing) : 6'h0;
	wire [5:0] ovf_set = (fr_valid && ovf) ? 6'(1 << fr_egr) : 6'h0;
	wire st_wr = wr && paddr == A_STICKY;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rw_valid <= 1'b0;
			rw_cf <= 48'h0;
			rw_rsv <= RST_WORD;
			rw_rsv_wr <= 1'b0;
			rw_org_sec <= 48'h0;
			rw_org_ns <= 30'h0;
			rw_org_wr <= 1'b0;
			rw_pre_cmd <= PRE_NONE;
			rw_pre_ref <= RST_WORD;
		end
		else
		begin
			rw_valid <= fr_valid;
			rw_cf <= !one ? fr_cf : ovf ? CF_MAX : cf_b[47:0];
			rw_rsv <= rsv_v;
			rw_rsv_wr <= fr_valid && one && rsv_wr;
			rw_org_sec <= sec_q;
			rw_org_ns <= ns_q;
			rw_org_wr <= fr_valid && fr_cmd == CMD_TOD;
			rw_pre_cmd <= !fr_valid ? PRE_NONE : fr_cmd == CMD_TOD ? PRE_CORR : one ? pre : PRE_NONE;
			rw_pre_ref <= free_q;
		end
	end
	// ---------------------------------------------------------------
	// Stamp FIFO; a two-step frame arriving with fewer than two free
	// entries is dropped whole; a second two-step frame on the next cycle loses its egress entry.
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
		if (push)
			fifo_mem[wp_q] <= push_ent;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wp_q <= 10'h000;
			rp_q <= 10'h000;
			cnt_q <= 11'h000;
			pend_q <= 1'b0;
			pend_ent_q <= 36'h0;
			rsv_st_q <= 6'h00;
			ovf_st_q <= 6'h00;
		end
		else
		begin
			wp_q <= wp_q + {9'h0, push};
			rp_q <= rp_q + {9'h0, pop};
			cnt_q <= cnt_q + {10'h0, push} - {10'h0, pop};
			pend_q <= two_push;
			pend_ent_q <= {1'b0, fr_ing, fr_stamp};
			rsv_st_q <= (rsv_st_q & ~(st_wr ? pwdata[5:0] : 6'h00)) | rsv_set;
			ovf_st_q <= (ovf_st_q & ~(st_wr ? pwdata[13:8] : 6'h00)) | ovf_set;
		end
	end
	// ---------------------------------------------------------------
	// Load/store controllers and configuration
	// ---------------------------------------------------------------
	logic [4:0] clk_lvl, irq_set;
	always_comb
	begin
		for (int n = 0; n < 5; n++)
		begin
			clk_lvl[n] = ctl_q[n][CTL_SYNC_BIT] ? arm_q[n] && {2'h0, ns_q} >= wlo_q[n]
				&& {2'h0, ns_q} < wlo_q[n] + whi_q[n] : arm_q[n] && ph_q[n] < whi_q[n];
			irq_set[n] = exec[n] || (ctl_q[n][1:0] == ACT_CLOCK && clk_lvl[n] && !lvl_q[n]);
		end
	end
	assign irq = |(ist_q & imask_q);
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rmode_q <= 2'h0;
			rint_q <= RST_WORD;
			ist_q <= 5'h00;
			imask_q <= 5'h00;
			arm_q <= 5'h00;
			lvl_q <= 5'h00;
			pin_prev_q <= 4'h0;
			pin_out <= 4'h0;
			pin_oe_n <= 4'hF;
			for (int p = 0; p < 8; p++)
			begin
				mode_q[p] <= MODE_FRONT;
				idly1_q[p] <= RST_WORD;
				idly2_q[p] <= RST_WORD;
				egress_delay_q[p] <= RST_WORD;
			end
			for (int n = 0; n < 5; n++)
			begin
				ctl_q[n] <= 5'h00;
				ts_sec_q[n] <= 48'h0;
				ts_ns_q[n] <= 30'h0;
				ts_free_q[n] <= RST_WORD;
				whi_q[n] <= RST_WORD;
				wlo_q[n] <= RST_WORD;
				ph_q[n] <= RST_WORD;
			end
		end
		else
		begin
			pin_prev_q <= pin_in;
			lvl_q <= clk_lvl;
			ist_q <= (ist_q & ~(wr && paddr == A_IRQ_STAT ? pwdata[4:0] : 5'h00)) | irq_set;
			if (wr && paddr == A_RATE_CFG)
				rmode_q <= pwdata[1:0];
			if (wr && paddr == A_RATE_INT)
				rint_q <= pwdata;
			if (wr && paddr == A_IRQ_MASK)
				imask_q <= pwdata[4:0];
			if (wr && in_port)
				case (paddr[3:2])
					2'h0: mode_q[pidx] <= pwdata[2:0];
					2'h1: idly1_q[pidx] <= pwdata;
					2'h2: idly2_q[pidx] <= pwdata;
					default: egress_delay_q[pidx] <= pwdata;
				endcase
			for (int n = 0; n < 5; n++)
			begin
				if (n < 4)
				begin
					pin_out[n] <= clk_lvl[n] ^ ctl_q[n][CTL_INV_BIT];
					pin_oe_n[n] <= ctl_q[n][1:0] != ACT_CLOCK;
				end
				ph_q[n] <= (ph_q[n] + {24'h0, step} >= whi_q[n] + wlo_q[n]) ? RST_WORD
					: ph_q[n] + {24'h0, step};
				if (exec[n] || (ctl_q[n][CTL_SYNC_BIT] && lvl_q[n] && !clk_lvl[n]))
					arm_q[n] <= 1'b0;
				if (exec[n] && ctl_q[n][1:0] == ACT_STORE)
				begin
					ts_sec_q[n] <= sec_q;
					ts_ns_q[n] <= ns_q;
					ts_free_q[n] <= free_q;
				end
			end
			if (wr && ctl_ok)
				case (cfld)
					3'h0:
					begin
						ctl_q[cidx] <= pwdata[4:0];
						arm_q[cidx] <= pwdata[CTL_ARM_BIT];
					end
					3'h1: ts_sec_q[cidx][47:32] <= pwdata[15:0];
					3'h2: ts_sec_q[cidx][31:0] <= pwdata;
					3'h3: ts_ns_q[cidx] <= pwdata[29:0];
					3'h5: whi_q[cidx] <= pwdata;
					3'h6: wlo_q[cidx] <= pwdata;
					default: ;
				endcase
		end
	end
	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_free_step;
		1'b1 |=> free_q == $past(free_q) + {24'h0, $past(step)};
	endproperty
	a_free_step: assert property (p_free_step) else $error("free count step wrong");
	property p_step_range;
		step == NOM_STEP || step == NOM_STEP + 8'h01 || step == NOM_STEP - 8'h01;
	endproperty
	a_step_range: assert property (p_step_range) else $error("step out of range");
	property p_rate;
		rmode_q == RATE_ADD && rtick |-> step == NOM_STEP + 8'h01;
	endproperty
	a_rate: assert property (p_rate) else $error("rate insert missing");
	property p_two_order;
		two_push |=> pend_q && $past(fr_egr) == fifo_mem[$past(wp_q)][34:32]
			&& fifo_mem[$past(wp_q)][35] ##1 !fifo_mem[$past(wp_q, 2) + 10'h1][35];
	endproperty
	a_two_order: assert property (p_two_order) else $error("stamp order wrong");
	property p_two_nodly;
		fr_valid && fr_cmd == CMD_TWO |=> rw_valid && rw_cf == $past(fr_cf);
	endproperty
	a_two_nodly: assert property (p_two_nodly) else $error("two-step changed field");
	property p_disabled;
		fr_valid && one && emode == MODE_DISABLED |=> rw_cf == $past(fr_cf) && rw_pre_cmd == PRE_NONE;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled port modified");
	property p_ovf;
		fr_valid && ovf |=> rw_cf == CF_MAX && ovf_st_q[$past(fr_egr)];
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not handled");
	property p_rsv;
		fr_valid && fr_cmd != CMD_NOP && fr_rsv != RST_WORD && fr_ing < 3'h6 |=> rsv_st_q[$past(fr_ing)];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved flag not set");
	property p_front_pre;
		fr_valid && one && emode == MODE_FRONT |=> rw_pre_cmd == PRE_CORR && rw_pre_ref == $past(free_q);
	endproperty
	a_front_pre: assert property (p_front_pre) else $error("front preamble wrong");
	property p_irq;
		|exec |=> |ist_q;
	endproperty
	a_irq: assert property (p_irq) else $error("operation left no interrupt");
	c_two: cover property (two_push ##1 pend_q);
	c_load: cover property (ld_hit && !dl_hit);
	c_clock: cover property (!lvl_q[0] && clk_lvl[0]);
	c_ovf: cover property (fr_valid && ovf);
endmodule

// ===== ptte_port_model.sv
`timescale 1ns/1ps
// ----
// Egress port and timing pin partner
// ----
module ptte_port_model
	import ptte_pkg::*;
(
	// Clock
	input wire logic clk,
	// Rewriter side
	input wire logic rw_valid,
	input wire logic [1:0] rw_pre_cmd,
	input wire logic [47:0] rw_cf,
	input wire logic [31:0] rw_pre_ref,
	input wire logic [31:0] free_ns_counter,
	// Pins
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe_n,
	input wire logic [3:0] ext_pin,
	output logic [3:0] pin_in,
	output logic [47:0] tx_cf
);
	// A pin the device drives follows it; otherwise the far end owns it.
	assign pin_in = (pin_out & ~pin_oe_n) | (ext_pin & pin_oe_n);
	// The port adds its own elapsed time a cycle late, as a slow port would.
	always_ff @(posedge clk)
		if (rw_valid)
			tx_cf <= (rw_pre_cmd == PRE_NONE) ? rw_cf : rw_cf + 48'(free_ns_counter - rw_pre_ref);
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench
	import ptte_pkg::*;
;
	// ----
	// Signals
	// ----
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, fr_valid, irq, e;
	logic rw_valid, rw_rsv_wr, rw_org_wr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, fr_stamp, fr_rsv, fr_egr_stamp, rw_rsv, rw_pre_ref;
	logic [31:0] free_ns_counter, cnt, f, r;
	logic [1:0] fr_cmd, fr_dly, rw_pre_cmd;
	logic [2:0] fr_ing, fr_egr;
	logic [47:0] fr_cf, rw_cf, rw_org_sec, tod_seconds, tx_cf;
	logic [29:0] rw_org_ns, tod_nanoseconds;
	logic [3:0] pin_in, pin_out, pin_oe_n, ext_pin;
	int mismatches, n_tests;
	ptte_engine DUT (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .fr_valid, .fr_cmd, .fr_dly, .fr_ing, .fr_egr, .fr_cf, .fr_stamp, .fr_rsv,
		.fr_egr_stamp, .rw_valid, .rw_cf, .rw_rsv, .rw_rsv_wr, .rw_org_sec, .rw_org_ns,
		.rw_org_wr, .rw_pre_cmd, .rw_pre_ref, .tod_seconds, .tod_nanoseconds, .free_ns_counter,
		.pin_in, .pin_out, .pin_oe_n, .irq);
	ptte_port_model pm (.clk, .rw_valid, .rw_pre_cmd, .rw_cf, .rw_pre_ref, .free_ns_counter,
		.pin_out, .pin_oe_n, .ext_pin, .pin_in, .tx_cf);
	initial
	begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	// Own nanosecond count, advancing one nominal period per cycle.
	always @(posedge clk or negedge nrst)
		cnt <= nrst ? cnt + 32'h32 : 32'h0;
	// ----
	// Tasks
	// ----
	task automatic chk(input string n, input logic [47:0] s, input logic [47:0] x);
		n_tests++;
		if (s !== x)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x);
		apb(0, a, 32'h0);
		chk(n, 48'(r), 48'(x));
	endtask
	task automatic frm(input logic [1:0] c, input logic [1:0] d, input logic [2:0] i,
		input logic [2:0] o, input logic [47:0] cf, input logic [31:0] st, input logic [31:0] rv);
		@(posedge clk);
		fr_valid <= 1;
		fr_cmd <= c;
		fr_dly <= d;
		fr_ing <= i;
		fr_egr <= o;
		fr_cf <= cf;
		fr_stamp <= st;
		fr_rsv <= rv;
		@(posedge clk);
		fr_valid <= 0;
		#1;
		f = cnt - 32'h32;
		chk("rw_valid", 48'(rw_valid), 48'h1);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (4000) @(posedge clk);
		mismatches++;
		finish_test;
	end
	// ----
	// Tests
	// ----
	initial
	begin
		{nrst, psel, penable, pwrite, fr_valid, fr_cmd, fr_dly, fr_ing, fr_egr} = 0;
		{paddr, pwdata, fr_cf, fr_stamp, fr_rsv, ext_pin} = 0;
		fr_egr_stamp = 32'h777;
		repeat (2) @(posedge clk);
		nrst <= 1;
		#1;
		chk("oe_n", 48'(pin_oe_n), 48'hF);
		apb(1, 12'h02C, 32'h64);
		apb(1, 12'h034, 32'h20);
		apb(1, 12'h030, 32'h5);
		apb(1, 12'h040, 32'h6);
		apb(1, 12'h050, 32'h2);
		apb(1, 12'h060, 32'h1);
		frm(CMD_ONE, DLY_EGRESS, 3'h1, 3'h0, 48'h1000, 32'h10, 32'h0);
		chk("cf", rw_cf, 48'h1064 + 48'(f - 32'h10));
		chk("pre", 48'(rw_pre_cmd), 48'(PRE_CORR));
		chk("ref", 48'(rw_pre_ref), 48'(f));
		frm(CMD_ONE, DLY_INGRESS1, 3'h1, 3'h1, 48'h1000, 32'h10, 32'h0);
		chk("cf", rw_cf, 48'h1020);
		frm(CMD_ONE, DLY_EGRESS, 3'h0, 3'h2, 48'h1000, 32'h10, 32'h0);
		chk("cf", rw_cf, 48'h1000);
		chk("pre", 48'(rw_pre_cmd), 48'(PRE_NONE));
		frm(CMD_ONE, 2'h0, 3'h3, 3'h0, 48'h1000, 32'h10, 32'h5);
		chk("cf", rw_cf, 48'h1000 + 48'(f - 32'h5));
		frm(CMD_ONE, 2'h0, 3'h4, 3'h3, 48'h1000, 32'h10, 32'h0);
		chk("cf", rw_cf, 48'h1000 + 48'(f));
		chk("rsv", {15'h0, rw_rsv_wr, rw_rsv}, {16'h1, f});
		frm(CMD_ONE, 2'h0, 3'h0, 3'h4, 48'h1000, 32'h10, 32'h0);
		chk("rsv", 48'(rw_rsv), 48'(f[29:0]));
		chk("pre", 48'(rw_pre_cmd), 48'(PRE_CORR_RSV));
		frm(CMD_ONE, 2'h0, 3'h0, 3'h0, CF_MAX, 32'h0, 32'h0);
		chk("cf", rw_cf, CF_MAX);
		frm(CMD_TOD, 2'h0, 3'h0, 3'h0, 48'h1000, 32'h0, 32'h0);
		chk("org", {17'h0, rw_org_wr, rw_org_ns}, {18'h1, f[29:0]});
		chk("pre", 48'(rw_pre_cmd), 48'(PRE_CORR));
		chk("org_sec", rw_org_sec, 48'h0);
		@(posedge clk);
		#1;
		chk("tx_cf", tx_cf, 48'h1032);
		rd("sticky", A_STICKY, 32'h108);
		$display("one-step tests done");
		frm(CMD_TWO, DLY_EGRESS, 3'h1, 3'h0, 48'h1000, 32'h10, 32'h0);
		chk("cf", rw_cf, 48'h1000);
		rd("info", A_FIFO_INFO, 32'h80000008);
		rd("data", A_FIFO_DATA, 32'h777);
		rd("info", A_FIFO_INFO, 32'h80000001);
		rd("data", A_FIFO_DATA, 32'h10);
		rd("info", A_FIFO_INFO, 32'h0);
		rd("unmapped", 12'hFFC, 32'h0);
		chk("err", 48'(e), 48'h1);
		$display("two-step tests done");
		apb(1, 12'h080, 32'h16);
		apb(1, 12'h100, 32'h12);
		#1;
		f = cnt;
		rd("irq", A_IRQ_STAT, 32'h10);
		rd("arm", 12'h080, 32'h16);
		rd("sfree", 12'h110, f);
		rd("sns", 12'h10C, {2'h0, f[29:0]});
		@(posedge clk);
		ext_pin <= 4'h1;
		rd("irq", A_IRQ_STAT, 32'h11);
		apb(1, A_IRQ_MASK, 32'h10);
		#1;
		chk("irq", 48'(irq), 48'h1);
		apb(1, A_IRQ_STAT, 32'h11);
		#1;
		chk("irq", 48'(irq), 48'h0);
		chk("free", 48'(free_ns_counter), 48'(cnt));
		chk("tod", 48'(tod_nanoseconds), 48'(cnt[29:0]));
		apb(1, 12'h0C8, 32'h5);
		apb(1, 12'h0CC, 32'h100);
		apb(1, 12'h0C0, 32'h10);
		@(posedge clk);
		#1;
		chk("sec", tod_seconds, 48'h5);
		chk("ns", 48'(tod_nanoseconds), 48'h100);
		apb(1, 12'h0B4, 32'h64);
		apb(1, 12'h0B8, 32'h64);
		apb(1, 12'h0A0, 32'h13);
		repeat (4) @(posedge clk);
		rd("irq", A_IRQ_STAT, 32'h6);
		chk("oe_n", 48'(pin_oe_n), 48'hD);
		#1;
		e = pin_out[1];
		repeat (2) @(posedge clk);
		#1;
		chk("wave", 48'(pin_out[1]), 48'(!e));
		apb(1, A_RATE_INT, 32'h1);
		apb(1, A_RATE_CFG, 32'h1);
		#1;
		f = free_ns_counter;
		repeat (4) @(posedge clk);
		#1;
		chk("rate", 48'(free_ns_counter - f), 48'hCA);
		$display("controller tests done");
		finish_test;
	end
endmodule
